// File: logic/fhs_regs.sv
// Module: host register front end of the floppy controller (decode, status A/B, drive output control)
// Functional notes
// - Decode offsets zero to seven, six reserved
// - Offset four/seven: status read, rate/config write
// - Basic mode: status A/B reads leave bus undriven
// - Enhanced status A layout, listed bits reset zero
// - Direction, head side, write protect polarities
// - Alternate status A layout and reset values
// - Step latch sets on step, clears on input read/resets
// - Enhanced status B layout with toggles, motors
// - Inactive data edges invert toggle bits
// - Status B motor/select bits survive software reset
// - Alternate status B layout and reset values
// - Alternate latches set on edges, clear on input read
// - Drive output control field layout, reset zero
// - Output control writable anytime, kept on soft reset
// - Binary drive select decode, one drive only
// - Bit two low holds controller reset
// - Back-to-back clear/set writes are valid reset
// - DMA enable gates requests except enhanced mode
// - Set motor bit asserts active-low motor output
module fhs_regs (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  // Compatibility mode
  input  wire fhs_pkg::fhs_mode_e   mode_in,
  // Host I/O access
  input  wire logic                 io_sel_in,
  input  wire logic                 io_rd_in,
  input  wire logic                 io_wr_in,
  input  wire logic [2:0]           io_addr_in,
  input  wire logic [7:0]           io_wdata_in,
  output logic      [7:0]           io_rdata_out,
  output logic                      io_rdata_oe_out,
  // Controller core side
  input  wire fhs_pkg::fhs_core_in_s core_in,
  input  wire logic [7:0]           core_main_status_in,
  input  wire logic [7:0]           core_fifo_rdata_in,
  input  wire logic [7:0]           core_input_status_in,
  output logic                      core_fifo_rd_out,
  output logic                      core_fifo_wr_out,
  output logic      [7:0]           core_wdata_out,
  output logic                      core_soft_reset_out,
  output logic      [7:0]           rate_select_out,
  output logic      [7:0]           config_control_out,
  output logic      [1:0]           tape_assign_out,
  output logic                      dma_req_out,
  output logic                      irq_out,
  // Drive interface
  input  wire fhs_pkg::fhs_drv_in_s drv_in,
  output fhs_pkg::fhs_drv_out_s     drv_out
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic rd_stb;  // Host read strobe
  logic wr_stb;  // Host write strobe
  logic rd_input;  // Read of input status register
  assign rd_stb   = io_sel_in & io_rd_in;
  assign wr_stb   = io_sel_in & io_wr_in;
  assign rd_input = rd_stb & (io_addr_in == fhs_pkg::OFF_INPUT_STATUS);

  // Core strobes are combinational handshakes
  assign core_fifo_rd_out = rd_stb & (io_addr_in == fhs_pkg::OFF_DATA_FIFO);
  assign core_fifo_wr_out = wr_stb & (io_addr_in == fhs_pkg::OFF_DATA_FIFO);
  assign core_wdata_out   = io_wdata_in;

  // ----------------------------------------------------------------
  // Write-side registers
  // ----------------------------------------------------------------
  logic [7:0] doc_ff;       // Drive output control
  logic [7:0] nxt_doc;
  logic [7:0] rate_ff;      // Data rate select
  logic [7:0] nxt_rate;
  logic [7:0] cfg_ff;       // Configuration control
  logic [7:0] nxt_cfg;
  logic [1:0] tape_ff;      // Tape drive assignment
  logic [1:0] nxt_tape;

  // Next values of write-side registers
  always_comb begin
    nxt_doc  = doc_ff;
    nxt_rate = rate_ff;
    nxt_cfg  = cfg_ff;
    nxt_tape = tape_ff;
    if (wr_stb) begin
      if (io_addr_in == fhs_pkg::OFF_DRIVE_OUTPUT) begin
        nxt_doc = io_wdata_in;
      end else if (io_addr_in == fhs_pkg::OFF_TAPE_ASSIGN) begin
        nxt_tape = io_wdata_in[1:0];
      end else if (io_addr_in == fhs_pkg::OFF_MAIN_STATUS) begin
        nxt_rate = io_wdata_in;
      end else if (io_addr_in == fhs_pkg::OFF_INPUT_STATUS) begin
        nxt_cfg = io_wdata_in;
      end
      // Offset six and the read-only slots ignore writes
    end
  end

  // Only hardware reset touches these; soft reset leaves them alone
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      doc_ff  <= fhs_pkg::DOC_RESET_VAL;
      rate_ff <= fhs_pkg::RATE_RESET_VAL;
      cfg_ff  <= fhs_pkg::CFG_RESET_VAL;
      tape_ff <= fhs_pkg::TAPE_RESET_VAL[1:0];
    end else begin
      doc_ff  <= nxt_doc;
      rate_ff <= nxt_rate;
      cfg_ff  <= nxt_cfg;
      tape_ff <= nxt_tape;
    end
  end

  assign rate_select_out    = rate_ff;
  assign config_control_out = cfg_ff;
  assign tape_assign_out    = tape_ff;

  // ----------------------------------------------------------------
  // Software reset
  // ----------------------------------------------------------------
  // Stretched to a minimum length so a clear-then-set pair of writes
  // still gives the core a full-width reset pulse
  localparam int SRST_CW = $clog2(fhs_pkg::SRST_MIN_CYCLES + 1);
  localparam logic [SRST_CW-1:0] SRST_LOAD = SRST_CW'(fhs_pkg::SRST_MIN_CYCLES);
  logic [SRST_CW-1:0] srst_cnt_ff;  // Remaining stretch cycles
  logic [SRST_CW-1:0] nxt_srst_cnt;

  // Reload while the bit is low, then count down
  always_comb begin
    nxt_srst_cnt = srst_cnt_ff;
    if (!doc_ff[fhs_pkg::DOC_SRST_BIT]) begin
      nxt_srst_cnt = SRST_LOAD;
    end else if (srst_cnt_ff != '0) begin
      nxt_srst_cnt = srst_cnt_ff - SRST_CW'(1);
    end
  end

  // Stretch counter register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      srst_cnt_ff <= '0;
    end else begin
      srst_cnt_ff <= nxt_srst_cnt;
    end
  end

  logic soft_rst;  // Controller reset from software
  assign soft_rst = ~doc_ff[fhs_pkg::DOC_SRST_BIT] | (srst_cnt_ff != '0);
  assign core_soft_reset_out = soft_rst;

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  // A drive counts as selected only while its code is set and its motor bit is on,
  // so a cleared register after reset selects no drive at all
  function automatic logic drive_on(logic [7:0] doc, logic [1:0] code);
    return (doc[fhs_pkg::DOC_DSEL_LSB +: 2] == code) & doc[fhs_pkg::DOC_MOTOR_LSB + code];
  endfunction

  // Drive outputs registered to keep them glitch free
  fhs_pkg::fhs_drv_out_s drv_ff;
  fhs_pkg::fhs_drv_out_s nxt_drv;

  // Binary decode: code 0 or 1 only, others select none
  always_comb begin
    nxt_drv.motor_on_n      = ~nxt_doc[fhs_pkg::DOC_MOTOR_LSB +: 4];
    nxt_drv.drive_select0_n = ~drive_on(nxt_doc, 2'h0);
    nxt_drv.drive_select1_n = ~drive_on(nxt_doc, 2'h1);
  end

  // Drive output register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      drv_ff <= '{motor_on_n: 4'hF, drive_select0_n: 1'b1, drive_select1_n: 1'b1};
    end else begin
      drv_ff <= nxt_drv;
    end
  end
  assign drv_out = drv_ff;

  // DMA and interrupt gating, open in enhanced mode
  logic dma_gate;
  assign dma_gate    = (mode_in == fhs_pkg::FHS_MODE_ENHANCED) | doc_ff[fhs_pkg::DOC_DMA_IRQ_ENABLE_BIT];
  assign dma_req_out = core_in.dma_req & dma_gate;
  assign irq_out     = core_in.irq_pending & dma_gate;

  // ----------------------------------------------------------------
  // Edge detection and latches
  // ----------------------------------------------------------------
  logic step_d_ff;   // Previous step level
  logic write_gate_d_ff;  // Previous write gate level
  logic rdat_d_ff;   // Previous read data (active low)
  logic wdat_d_ff;   // Previous write data (active low)
  logic step_lat_ff, nxt_step_lat;
  logic wg_lat_ff,   nxt_wg_lat;
  logic rd_lat_ff,   nxt_rd_lat;
  logic wd_lat_ff,   nxt_wd_lat;
  logic rd_tog_ff,   nxt_rd_tog;
  logic wd_tog_ff,   nxt_wd_tog;
  logic rd_inact, wd_inact, step_act, wg_act;

  // Inactive edge of an active-low pulse is its rising edge
  assign rd_inact = drv_in.read_data_n & ~rdat_d_ff;
  assign wd_inact = core_in.write_data_n & ~wdat_d_ff;
  assign step_act = core_in.step & ~step_d_ff;
  assign wg_act   = core_in.write_gate & ~write_gate_d_ff;

  // Set wins over clear so no edge is lost in a clearing read
  always_comb begin
    nxt_step_lat = (step_lat_ff & ~rd_input & ~soft_rst) | step_act;
    nxt_wg_lat   = (wg_lat_ff & ~rd_input) | wg_act;
    nxt_rd_lat   = (rd_lat_ff & ~rd_input) | rd_inact;
    nxt_wd_lat   = (wd_lat_ff & ~rd_input) | wd_inact;
    nxt_rd_tog   = rd_tog_ff ^ rd_inact;
    nxt_wd_tog   = wd_tog_ff ^ wd_inact;
  end

  // Latch and edge history registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      // History follows the pins under reset: no false edge at release
      step_d_ff   <= core_in.step;
      write_gate_d_ff  <= core_in.write_gate;
      rdat_d_ff   <= drv_in.read_data_n;
      wdat_d_ff   <= core_in.write_data_n;
      step_lat_ff <= 1'b0;
      wg_lat_ff   <= 1'b0;
      rd_lat_ff   <= 1'b0;
      wd_lat_ff   <= 1'b0;
      rd_tog_ff   <= 1'b0;
      wd_tog_ff   <= 1'b0;
    end else begin
      step_d_ff   <= core_in.step;
      write_gate_d_ff  <= core_in.write_gate;
      rdat_d_ff   <= drv_in.read_data_n;
      wdat_d_ff   <= core_in.write_data_n;
      step_lat_ff <= nxt_step_lat;
      wg_lat_ff   <= nxt_wg_lat;
      rd_lat_ff   <= nxt_rd_lat;
      wd_lat_ff   <= nxt_wd_lat;
      rd_tog_ff   <= nxt_rd_tog;
      wd_tog_ff   <= nxt_wd_tog;
    end
  end

  // ----------------------------------------------------------------
  // Status layouts
  // ----------------------------------------------------------------
  logic [7:0] stat_a, stat_b;
  logic [3:0] ds_n;  // Active-low select status of four drives

  // Status A/B per mode; core inputs pass through unmasked
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ds_n[i] = ~drive_on(doc_ff, 2'(i));
    end
    if (mode_in == fhs_pkg::FHS_MODE_ALTERNATE) begin
      stat_a = {core_in.irq_pending, core_in.dma_req, step_lat_ff,
                ~drv_in.track_zero_n, ~core_in.head_side, ~drv_in.index_pulse_n,
                ~drv_in.write_protect_n, ~core_in.step_inward};
      stat_b = {drv_in.second_drive_present_n, ds_n[1], ds_n[0],
                wd_lat_ff, rd_lat_ff, wg_lat_ff, ds_n[3], ds_n[2]};
    end else begin
      stat_a = {core_in.irq_pending, drv_in.second_drive_present_n, core_in.step,
                drv_in.track_zero_n, core_in.head_side, drv_in.index_pulse_n,
                drv_in.write_protect_n, core_in.step_inward};
      stat_b = {2'b11, doc_ff[0], wd_tog_ff, rd_tog_ff,
                core_in.write_gate, doc_ff[5], doc_ff[4]};
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff, nxt_rdata;
  logic       oe_ff, nxt_oe;

  // Read decode; unmapped slot drives zero
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_oe    = rd_stb;
    if (io_addr_in == fhs_pkg::OFF_HOST_STATUS_A) begin
      nxt_rdata = stat_a;
      nxt_oe    = rd_stb & (mode_in != fhs_pkg::FHS_MODE_BASIC);
    end else if (io_addr_in == fhs_pkg::OFF_HOST_STATUS_B) begin
      nxt_rdata = stat_b;
      nxt_oe    = rd_stb & (mode_in != fhs_pkg::FHS_MODE_BASIC);
    end else if (io_addr_in == fhs_pkg::OFF_DRIVE_OUTPUT) begin
      nxt_rdata = doc_ff;
    end else if (io_addr_in == fhs_pkg::OFF_TAPE_ASSIGN) begin
      nxt_rdata = {6'h00, tape_ff} & fhs_pkg::TAPE_RD_MASK;
    end else if (io_addr_in == fhs_pkg::OFF_MAIN_STATUS) begin
      nxt_rdata = core_main_status_in;
    end else if (io_addr_in == fhs_pkg::OFF_DATA_FIFO) begin
      nxt_rdata = core_fifo_rdata_in;
    end else if (io_addr_in == fhs_pkg::OFF_INPUT_STATUS) begin
      nxt_rdata = core_input_status_in;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // Read data register, one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 8'h00;
      oe_ff    <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      oe_ff    <= nxt_oe;
    end
  end
  assign io_rdata_out    = rdata_ff;
  assign io_rdata_oe_out = oe_ff;
endmodule

// File: logic/fhs_pkg.sv
// Package: offsets, field positions, reset values and carrier types for the floppy host register front end
package fhs_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte locations from the controller base)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_HOST_STATUS_A   = 3'h0;
  localparam logic [2:0] OFF_HOST_STATUS_B   = 3'h1;
  localparam logic [2:0] OFF_DRIVE_OUTPUT    = 3'h2;
  localparam logic [2:0] OFF_TAPE_ASSIGN     = 3'h3;
  localparam logic [2:0] OFF_MAIN_STATUS     = 3'h4;
  localparam logic [2:0] OFF_DATA_FIFO       = 3'h5;
  localparam logic [2:0] OFF_RESERVED_GAP    = 3'h6;
  localparam logic [2:0] OFF_INPUT_STATUS    = 3'h7;

  // ----------------------------------------------------------------
  // Drive output control field positions
  // ----------------------------------------------------------------
  localparam int DOC_DSEL_LSB  = 0;
  localparam int DOC_SRST_BIT  = 2;
  localparam int DOC_DMA_IRQ_ENABLE_BIT = 3;
  localparam int DOC_MOTOR_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DOC_RESET_VAL  = 8'h00;
  localparam logic [7:0] RATE_RESET_VAL = 8'h02;
  localparam logic [7:0] CFG_RESET_VAL  = 8'h02;
  localparam logic [7:0] TAPE_RESET_VAL = 8'h00;
  localparam logic [7:0] TAPE_RD_MASK   = 8'h03;

  // ----------------------------------------------------------------
  // Timing: least software reset length
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SRST_MIN_NS     = 100;
  localparam int SRST_MIN_CYCLES = (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FHS_MODE_BASIC     = 2'b00,
    FHS_MODE_ENHANCED  = 2'b01,
    FHS_MODE_ALTERNATE = 2'b10
  } fhs_mode_e;

  // Drive interface level inputs
  typedef struct packed {
    logic second_drive_present_n;
    logic track_zero_n;
    logic index_pulse_n;
    logic write_protect_n;
    logic read_data_n;
  } fhs_drv_in_s;

  // Signals from the controller core
  typedef struct packed {
    logic irq_pending;
    logic dma_req;
    logic step;
    logic head_side;
    logic step_inward;
    logic write_gate;
    logic write_data_n;
  } fhs_core_in_s;

  // Drive select and motor outputs
  typedef struct packed {
    logic [3:0] motor_on_n;
    logic       drive_select0_n;
    logic       drive_select1_n;
  } fhs_drv_out_s;
endpackage

// File: dv/fhs_regs_assertions.sv
// Checker: port-level assertions for the floppy host register front end
module fhs_regs_assertions (
  // Clock and reset
  input wire logic                  clk_sys_in,
  input wire logic                  sys_rst_in,
  // Host side
  input wire fhs_pkg::fhs_mode_e    mode_in,
  input wire logic                  io_sel_in,
  input wire logic                  io_rd_in,
  input wire logic                  io_wr_in,
  input wire logic [2:0]            io_addr_in,
  input wire logic [7:0]            io_wdata_in,
  input wire logic [7:0]            io_rdata_out,
  input wire logic                  io_rdata_oe_out,
  // Core and drive side
  input wire fhs_pkg::fhs_core_in_s core_in,
  input wire logic [7:0]            core_main_status_in,
  input wire logic                  core_soft_reset_out,
  input wire logic                  dma_req_out,
  input wire logic                  irq_out,
  input wire fhs_pkg::fhs_drv_out_s drv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic rd_c;  // Read taken this edge
  logic wr2_c; // Write to drive output control
  logic bas_c; // Basic mode selected
  assign rd_c  = io_sel_in && io_rd_in;
  assign wr2_c = io_sel_in && io_wr_in && (io_addr_in == fhs_pkg::OFF_DRIVE_OUTPUT);
  assign bas_c = (mode_in == fhs_pkg::FHS_MODE_BASIC);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_basic_hiz: assert property (rd_c && bas_c && io_addr_in <= 3'h1 |=> !io_rdata_oe_out)
    else $error("status read drove bus in basic mode");
  chk_read_drive: assert property (rd_c && (!bas_c || io_addr_in > 3'h1) |=> io_rdata_oe_out)
    else $error("read did not drive bus");
  chk_main_stat: assert property (rd_c && io_addr_in == 3'h4 |=> io_rdata_out == $past(core_main_status_in))
    else $error("main status read wrong");
  chk_motor_map: assert property (wr2_c |=> drv_out.motor_on_n == ~$past(io_wdata_in[7:4]))
    else $error("motor outputs do not follow write");
  chk_dsel_map: assert property (wr2_c |=>
    drv_out.drive_select0_n == !($past(io_wdata_in[1:0]) == 2'h0 && $past(io_wdata_in[4]))
    && drv_out.drive_select1_n == !($past(io_wdata_in[1:0]) == 2'h1 && $past(io_wdata_in[5])))
    else $error("drive select decode wrong");
  chk_srst_hold: assert property (wr2_c && !io_wdata_in[2] |=> core_soft_reset_out)
    else $error("soft reset not entered");
  chk_srst_pair: assert property ((wr2_c && !io_wdata_in[2]) ##1 (wr2_c && io_wdata_in[2])
    |=> core_soft_reset_out [*8])
    else $error("back-to-back soft reset too short");
  chk_dma_gate: assert property (!bas_c && mode_in == fhs_pkg::FHS_MODE_ENHANCED
    |-> dma_req_out == core_in.dma_req && irq_out == core_in.irq_pending)
    else $error("requests gated in enhanced mode");
  chk_dma_src: assert property (dma_req_out |-> core_in.dma_req)
    else $error("request without core source");
  // Main scenarios
  cov_pair: cover property ((wr2_c && !io_wdata_in[2]) ##1 (wr2_c && io_wdata_in[2]));
  cov_hiz: cover property (rd_c && bas_c && io_addr_in == 3'h1);
  cov_dma: cover property (core_in.dma_req && !dma_req_out);
endmodule
bind fhs_regs fhs_regs_assertions fhs_regs_assertions_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .mode_in(mode_in), .io_sel_in(io_sel_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_addr_in(io_addr_in),
  .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_rdata_oe_out(io_rdata_oe_out), .core_in(core_in),
  .core_main_status_in(core_main_status_in), .core_soft_reset_out(core_soft_reset_out),
  .dma_req_out(dma_req_out), .irq_out(irq_out), .drv_out(drv_out));

// File: dv/fhs_drive_model.sv
// Partner model: drive levels and read flux pulses
module fhs_drive_model (
  input  wire logic                  clk_sys_in,
  input  wire logic [3:0]            lvl_in,
  input  wire logic                  pulse_in,
  input  wire fhs_pkg::fhs_drv_out_s drv_out_in,
  output fhs_pkg::fhs_drv_in_s       drv_in_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_n_ff; // Read data, idles high
  logic sel;     // Some drive selected
  // One-cycle low pulse per request
  always_ff @(posedge clk_sys_in) begin
    rd_n_ff <= !pulse_in;
  end
  // Unselected drives float, the pull-ups win
  assign sel = !drv_out_in.drive_select0_n || !drv_out_in.drive_select1_n;
  assign drv_in_out = {sel ? lvl_in : 4'hF, rd_n_ff};
endmodule

// File: dv/fhs_regs_tb.sv
// Testbench: self-checking run of the floppy host register front end
module fhs_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys_in, sys_rst_in, pulse, oe, srst, dma, irq;
  logic [13:0]           bus;  // sel, rd, wr, addr, data
  logic [7:0]            rdata, main_status, dir, v, rate, cfg;
  logic [3:0]            lvl;
  logic [1:0]            tape; // Tape assignment output
  fhs_pkg::fhs_mode_e    mode;
  fhs_pkg::fhs_core_in_s core;
  fhs_pkg::fhs_drv_in_s  drv;
  fhs_pkg::fhs_drv_out_s dout;
  logic [7:0]            expq[$]; // Expected read data
  int                    n_errors, compares, seed;
  fhs_regs fhs_regs_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .mode_in(mode), .io_sel_in(bus[13]),
    .io_rd_in(bus[12]), .io_wr_in(bus[11]), .io_addr_in(bus[10:8]), .io_wdata_in(bus[7:0]),
    .io_rdata_out(rdata), .io_rdata_oe_out(oe), .core_in(core), .core_main_status_in(main_status),
    .core_fifo_rdata_in(8'h5A), .core_input_status_in(dir), .core_fifo_rd_out(), .core_fifo_wr_out(),
    .core_wdata_out(), .core_soft_reset_out(srst), .rate_select_out(rate), .config_control_out(cfg),
    .tape_assign_out(tape), .dma_req_out(dma), .irq_out(irq), .drv_in(drv), .drv_out(dout));
  fhs_drive_model fhs_drive_model_i (.clk_sys_in(clk_sys_in), .lvl_in(lvl), .pulse_in(pulse),
    .drv_out_in(dout), .drv_in_out(drv));
  // Clock, 10 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = !clk_sys_in;
  end
  task automatic tick();
    @(posedge clk_sys_in);
    #2;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes stay up; caller ends a burst with idle
  task automatic acc(logic wr, logic [2:0] a, logic [7:0] d);
    bus = {1'b1, !wr, wr, a, d};
    tick();
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic idle();
    bus = '0;
    tick();
  endtask
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] st_a(logic lat);
    if (mode == fhs_pkg::FHS_MODE_ALTERNATE)
      return {core.irq_pending, core.dma_req, lat, !drv.track_zero_n, !core.head_side, !drv.index_pulse_n,
              !drv.write_protect_n, !core.step_inward};
    return {core.irq_pending, drv.second_drive_present_n, core.step, drv.track_zero_n, core.head_side,
            drv.index_pulse_n, drv.write_protect_n, core.step_inward};
  endfunction
  // Latch argument: write data, read data, write gate
  function automatic logic [7:0] st_b(logic [7:0] doc, logic [2:0] lat);
    logic [3:0] dsn;
    dsn = ~(doc[7:4] & (4'h1 << doc[1:0]));
    if (mode == fhs_pkg::FHS_MODE_ALTERNATE)
      return {drv.second_drive_present_n, dsn[1], dsn[0], lat, dsn[3], dsn[2]};
    return {2'b11, doc[0], lat[2:1], core.write_gate, doc[5:4]};
  endfunction
  // Monitor: each driven read takes the oldest note
  always @(posedge clk_sys_in) begin
    #1;
    if (oe === 1'b1) begin
      if (expq.size() == 0)
        check("unexpected read", 8'h00, 8'hFF);
      else
        check("read data", rdata, expq.pop_front());
    end
  end
  // Watchdog, run needs far less
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
  initial begin
    seed = 32'hefd8;
    bus = '0;
    core = 7'h01;
    lvl = 4'hF;
    pulse = 1'b0;
    mode = fhs_pkg::FHS_MODE_ENHANCED;
    main_status = 8'($random(seed));
    dir = 8'($random(seed));
    sys_rst_in = 1'b1;
    repeat (3) tick();
    sys_rst_in = 1'b0;
    // Reset values and decode
    check("rate", rate, fhs_pkg::RATE_RESET_VAL);
    check("config", cfg, fhs_pkg::CFG_RESET_VAL);
    rd(3'h2, 8'h00);
    rd(3'h1, 8'hC0);
    rd(3'h0, st_a(1'b0));
    rd(3'h6, 8'h00);
    rd(3'h4, main_status);
    rd(3'h7, dir);
    acc(1'b1, 3'h3, 8'hFF);
    rd(3'h3, 8'h03);
    rd(3'h5, 8'h5A);
    check("tape", {6'h0, tape}, 8'h03);
    mode = fhs_pkg::FHS_MODE_ALTERNATE;
    rd(3'h0, st_a(1'b0));
    // Drive 0 on, so its pin levels reach the status registers
    acc(1'b1, 3'h2, 8'h1C);
    idle();
    $display("test reset done");
    // Random pin levels in every mode
    for (int i = 0; i < 9; i++) begin
      core = 7'(($random(seed) & 7'h6C) | 7'h01);
      lvl = 4'($random(seed));
      mode = fhs_pkg::fhs_mode_e'(i % 3);
      tick();
      rd(3'h0, st_a(1'b0));
      if (mode == fhs_pkg::FHS_MODE_BASIC)
        void'(expq.pop_back());
      idle();
    end
    $display("test status done");
    // Every drive select code, gating of requests
    core = 7'h61;
    for (int d = 0; d < 4; d++) begin
      v = {4'($random(seed)) | (4'h1 << d), 2'(d) & 2'h2 ? 1'b1 : 1'b0, 1'b1, 2'(d)};
      mode = fhs_pkg::FHS_MODE_ENHANCED;
      acc(1'b1, 3'h2, v);
      check("motor", {4'h0, dout.motor_on_n}, {4'h0, ~v[7:4]});
      check("select", {6'h0, dout.drive_select1_n, dout.drive_select0_n},
            {6'h0, d != 1 || !v[5], d != 0 || !v[4]});
      rd(3'h2, v);
      rd(3'h1, st_b(v, 3'h0));
      mode = fhs_pkg::FHS_MODE_ALTERNATE;
      rd(3'h1, st_b(v, 3'h0));
      check("dma irq", {6'h0, dma, irq}, {6'h0, v[3], v[3]});
      idle();
    end
    $display("test output control done");
    // Soft reset keeps rate, config and output control
    acc(1'b1, 3'h4, 8'h15);
    acc(1'b1, 3'h7, 8'h01);
    acc(1'b1, 3'h2, v & 8'hFB);
    idle();
    repeat (20) tick();
    check("held reset", {7'h0, srst}, 8'h01);
    acc(1'b1, 3'h2, v & 8'hFB);
    acc(1'b1, 3'h2, v);
    check("pulse reset", {7'h0, srst}, 8'h01);
    idle();
    repeat (14) tick();
    check("reset ends", {7'h0, srst}, 8'h00);
    check("rate kept", rate, 8'h15);
    check("config kept", cfg, 8'h01);
    rd(3'h2, v);
    mode = fhs_pkg::FHS_MODE_ENHANCED;
    rd(3'h1, st_b(v, 3'h0));
    idle();
    $display("test soft reset done");
    // Toggles and latches
    repeat (3) begin
      pulse = 1'b1;
      tick();
      pulse = 1'b0;
      repeat (2) tick();
    end
    repeat (2) begin
      core.write_data_n = 1'b0;
      tick();
      core.write_data_n = 1'b1;
      tick();
    end
    core.write_gate = 1'b1;
    tick();
    core.step = 1'b1;
    tick();
    core.step = 1'b0;
    tick();
    rd(3'h1, st_b(v, 3'b010));
    mode = fhs_pkg::FHS_MODE_ALTERNATE;
    rd(3'h1, st_b(v, 3'b111));
    rd(3'h0, st_a(1'b1));
    rd(3'h7, dir);
    rd(3'h0, st_a(1'b0));
    rd(3'h1, st_b(v, 3'b000));
    idle();
    $display("test latches done");
    // Hardware reset in mid-run
    sys_rst_in = 1'b1;
    repeat (2) tick();
    sys_rst_in = 1'b0;
    check("motor reset", {4'h0, dout.motor_on_n}, 8'h0F);
    check("select reset", {6'h0, dout.drive_select1_n, dout.drive_select0_n}, 8'h03);
    mode = fhs_pkg::FHS_MODE_ENHANCED;
    rd(3'h1, st_b(8'h00, 3'h0));
    mode = fhs_pkg::FHS_MODE_ALTERNATE;
    rd(3'h1, st_b(8'h00, 3'h0));
    idle();
    repeat (3) tick();
    $display("test hard reset done");
    summarize();
  end
endmodule
